// [core/bcd_core.sv]
// Bit-clear and flag-branch decode/execute with APB control registers
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module bcd_core (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic [bcd_pkg::APB_AW-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       instr_valid,
    input  wire logic [15:0]                instr_word,
    input  wire logic [bcd_pkg::PC_W-1:0]   instr_addr,
    output logic                            instr_ready,
    input  wire logic                       flag_carry,
    input  wire logic                       flag_negative,
    input  wire logic                       flag_overflow,
    output logic                            flag_wr_en,
    input  wire logic [bcd_pkg::FADDR_W-1:0] idx_base,
    output logic                            rf_rd_en,
    output logic      [bcd_pkg::FADDR_W-1:0] rf_rd_addr,
    input  wire logic [bcd_pkg::DATA_W-1:0] rf_rd_data,
    output logic                            rf_wr_en,
    output logic      [bcd_pkg::FADDR_W-1:0] rf_wr_addr,
    output logic      [bcd_pkg::DATA_W-1:0] rf_wr_data,
    output logic                            pc_load,
    output logic      [bcd_pkg::PC_W-1:0]   pc_out
);

    // ****************************************************************
    // Phase enables and state
    // ****************************************************************
    logic [3:0]                   phase;
    bcd_pkg::bcd_state_t          state_q;
    logic                         accept;
    logic                         is_bcf_w;
    logic                         is_br_w;
    logic [bcd_pkg::FADDR_W-1:0]  faddr_w;
    logic                         is_bcf_q;
    logic                         is_br_q;
    logic [3:0]                   cond_q;
    logic [2:0]                   bit_q;
    logic [7:0]                   n_q;
    logic [bcd_pkg::PC_W-1:0]     here_q;
    logic [bcd_pkg::DATA_W-1:0]   rd_data_q;
    logic                         taken_w;
    logic [bcd_pkg::PC_W-1:0]     target_w;
    logic                         ext_en_q;
    logic [3:0]                   bank_q;
    logic                         unsup_q;
    logic                         taken_q;
    logic [15:0]                  count_q;
    logic                         apb_wr;
    logic                         mapped_w;
    logic [31:0]                  rd_mux_w;
    logic                         err_q;
    logic [31:0]                  prdata_q;

    bcd_phase_gen u_phase (
        .clk   (clk),
        .srst  (srst),
        .phase (phase)
    );

    // Ready only in the first phase of a free instruction cycle
    assign instr_ready = phase[0] && (state_q == bcd_pkg::ST_IDLE);
    assign accept      = instr_ready && instr_valid;

    // ****************************************************************
    // Decode (first phase)
    // ****************************************************************
    always_comb begin
        is_bcf_w = (instr_word[15:12] == bcd_pkg::OPC_BIT_CLEAR);
        is_br_w  = 1'b0;
        if (instr_word[15:12] == bcd_pkg::OPC_COND_BR) begin
            case (instr_word[11:8])
                bcd_pkg::COND_CARRY:    is_br_w = 1'b1;
                bcd_pkg::COND_NO_CARRY: is_br_w = 1'b1;
                bcd_pkg::COND_NO_OVFL:  is_br_w = 1'b1;
                bcd_pkg::COND_NEGATIVE: is_br_w = 1'b1;
                bcd_pkg::COND_NON_NEG:  is_br_w = 1'b1;
                default:                is_br_w = 1'b0;
            endcase
        end
    end

    // File address resolution for the operand
    always_comb begin
        if (instr_word[8]) begin
            faddr_w = {bank_q, instr_word[7:0]};
        end else if (ext_en_q && (instr_word[7:0] <= bcd_pkg::IDX_LIMIT))
        begin
            // Wraps at 4K like the data space itself
            faddr_w = idx_base + {4'h0, instr_word[7:0]};
        end else if (instr_word[7:0] < bcd_pkg::ACCESS_SPLIT) begin
            faddr_w = {bcd_pkg::ACCESS_LO_BANK, instr_word[7:0]};
        end else begin
            faddr_w = {bcd_pkg::ACCESS_HI_BANK, instr_word[7:0]};
        end
    end

    // ****************************************************************
    // Cycle sequencing
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= bcd_pkg::ST_IDLE;
        end else begin
            case (state_q)
                bcd_pkg::ST_IDLE: begin
                    if (accept && (is_bcf_w || is_br_w)) begin
                        state_q <= bcd_pkg::ST_EXEC;
                    end
                end
                bcd_pkg::ST_EXEC: begin
                    if (phase[3]) begin
                        // Taken branch costs a whole extra cycle
                        state_q <= (is_br_q && taken_q) ? bcd_pkg::ST_FLUSH
                                                        : bcd_pkg::ST_IDLE;
                    end
                end
                bcd_pkg::ST_FLUSH: begin
                    if (phase[3]) begin
                        state_q <= bcd_pkg::ST_IDLE;
                    end
                end
                default: state_q <= bcd_pkg::ST_IDLE;
            endcase
        end
    end

    // Latched instruction fields
    always_ff @(posedge clk) begin
        if (srst) begin
            is_bcf_q <= 1'b0;
            is_br_q  <= 1'b0;
            cond_q   <= 4'h0;
            bit_q    <= 3'h0;
            n_q      <= 8'h00;
            here_q   <= bcd_pkg::PC_RST;
        end else if (accept) begin
            is_bcf_q <= is_bcf_w;
            is_br_q  <= is_br_w;
            cond_q   <= instr_word[11:8];
            bit_q    <= instr_word[11:9];
            n_q      <= instr_word[7:0];
            here_q   <= instr_addr;
        end
    end

    // ****************************************************************
    // File register read-modify-write
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            rf_rd_en   <= 1'b0;
            rf_rd_addr <= '0;
            rd_data_q  <= '0;
            rf_wr_en   <= 1'b0;
            rf_wr_addr <= '0;
            rf_wr_data <= '0;
        end else begin
            if (accept && is_bcf_w) begin
                rf_rd_en   <= 1'b1;
                rf_rd_addr <= faddr_w;
            end else if (phase[1]) begin
                rf_rd_en <= 1'b0;
            end
            if (phase[1] && rf_rd_en) begin
                rd_data_q <= rf_rd_data;
            end
            if (phase[2] && (state_q == bcd_pkg::ST_EXEC) && is_bcf_q) begin
                rf_wr_en   <= 1'b1;
                rf_wr_addr <= rf_rd_addr;
                rf_wr_data <= rd_data_q & ~(8'h01 << bit_q);
            end else if (phase[3]) begin
                rf_wr_en <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Branch evaluation and program counter
    // ****************************************************************
    always_comb begin
        case (cond_q)
            bcd_pkg::COND_CARRY:    taken_w = flag_carry;
            bcd_pkg::COND_NO_CARRY: taken_w = !flag_carry;
            bcd_pkg::COND_NO_OVFL:  taken_w = !flag_overflow;
            bcd_pkg::COND_NEGATIVE: taken_w = flag_negative;
            bcd_pkg::COND_NON_NEG:  taken_w = !flag_negative;
            default:                taken_w = 1'b0;
        endcase
    end

    // Sign-extended offset, doubled, on top of the advanced counter
    assign target_w = here_q + bcd_pkg::PC_STEP
                    + {{(bcd_pkg::PC_W-9){n_q[7]}}, n_q, 1'b0};

    always_ff @(posedge clk) begin
        if (srst) begin
            pc_out  <= bcd_pkg::PC_RST;
            pc_load <= 1'b0;
            taken_q <= 1'b0;
        end else begin
            if (phase[2] && (state_q == bcd_pkg::ST_EXEC)) begin
                if (is_br_q && taken_w) begin
                    pc_out  <= target_w;
                    pc_load <= 1'b1;
                    taken_q <= 1'b1;
                end else begin
                    pc_out  <= here_q + bcd_pkg::PC_STEP;
                    taken_q <= 1'b0;
                end
            end else if (phase[3]) begin
                pc_load <= 1'b0;
            end
        end
    end

    // Status flags belong to the ALU; this block never writes them
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_wr_en <= 1'b0;
        end else begin
            flag_wr_en <= 1'b0;
        end
    end

    // ****************************************************************
    // APB slave, zero wait states
    // ****************************************************************
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_q;
    assign prdata  = prdata_q;
    assign apb_wr  = psel && penable && pwrite && !err_q;

    always_comb begin
        mapped_w = 1'b1;
        rd_mux_w = 32'h00000000;
        case (paddr)
            bcd_pkg::REG_CTRL:  rd_mux_w[bcd_pkg::CTRL_EXT_BIT] = ext_en_q;
            bcd_pkg::REG_BANK:  rd_mux_w[3:0] = bank_q;
            bcd_pkg::REG_STAT: begin
                rd_mux_w[bcd_pkg::STAT_BUSY_BIT] =
                    (state_q != bcd_pkg::ST_IDLE);
                rd_mux_w[bcd_pkg::STAT_UNSUP_BIT] = unsup_q;
                rd_mux_w[bcd_pkg::STAT_TAKEN_BIT] = taken_q;
                rd_mux_w[bcd_pkg::STAT_FLUSH_BIT] =
                    (state_q == bcd_pkg::ST_FLUSH);
            end
            bcd_pkg::REG_PC:    rd_mux_w[bcd_pkg::PC_W-1:0] = pc_out;
            bcd_pkg::REG_COUNT: rd_mux_w[15:0] = count_q;
            default:            mapped_w = 1'b0;
        endcase
    end

    // Read data and error decided in the setup cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_q <= 32'h00000000;
            err_q    <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux_w;
            err_q    <= !mapped_w;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ext_en_q <= bcd_pkg::CTRL_EXT_RST;
            bank_q   <= bcd_pkg::BANK_RST;
        end else if (apb_wr) begin
            if (paddr == bcd_pkg::REG_CTRL) begin
                ext_en_q <= pwdata[bcd_pkg::CTRL_EXT_BIT];
            end
            if (paddr == bcd_pkg::REG_BANK) begin
                bank_q <= pwdata[3:0];
            end
        end
    end

    // Sticky unsupported-opcode flag: a new event beats the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            unsup_q <= 1'b0;
        end else if (accept && !is_bcf_w && !is_br_w) begin
            unsup_q <= 1'b1;
        end else if (apb_wr && (paddr == bcd_pkg::REG_STAT)
                     && pwdata[bcd_pkg::STAT_UNSUP_BIT]) begin
            unsup_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= bcd_pkg::COUNT_RST;
        end else if (phase[3] && (state_q == bcd_pkg::ST_EXEC)) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_clear_one_bit: assert property (
        rf_wr_en && !$past(rf_wr_en) |->
            rf_wr_data == ($past(rf_rd_data, 2) & ~(8'h01 << bit_q)))
        else $error("bit clear wrote wrong data");
    a_access_bank: assert property (
        accept && is_bcf_w && !instr_word[8]
        && !(ext_en_q && instr_word[7:0] <= 8'h5f) |=>
            rf_rd_addr == {($past(instr_word[7:0]) >= 8'h60)
                           ? 4'hf : 4'h0, $past(instr_word[7:0])})
        else $error("access bank address wrong");
    a_banked_addr: assert property (
        accept && is_bcf_w && instr_word[8] |=>
            rf_rd_addr == {$past(bank_q), $past(instr_word[7:0])})
        else $error("banked address wrong");
    a_indexed_addr: assert property (
        accept && is_bcf_w && !instr_word[8] && ext_en_q
        && instr_word[7:0] <= 8'h5f |=>
            rf_rd_addr == $past(idx_base) + {4'h0, $past(instr_word[7:0])})
        else $error("indexed offset address wrong");
    a_neg_branch: assert property (
        accept && instr_word[15:8] == 8'he6 |->
            ##3 pc_load == $past(flag_negative))
        else $error("negative branch decision wrong");
    a_nocarry_branch: assert property (
        accept && instr_word[15:8] == 8'he3 |->
            ##3 pc_load == !$past(flag_carry))
        else $error("no-carry branch decision wrong");
    a_nonneg_branch: assert property (
        accept && instr_word[15:8] == 8'he7 |->
            ##3 pc_load == !$past(flag_negative))
        else $error("non-negative branch decision wrong");
    a_noovfl_branch: assert property (
        accept && instr_word[15:8] == 8'he5 |->
            ##3 pc_load == !$past(flag_overflow))
        else $error("no-overflow branch decision wrong");
    a_carry_branch: assert property (
        accept && instr_word[15:8] == 8'he2 |->
            ##3 pc_load == $past(flag_carry))
        else $error("carry branch decision wrong");
    a_taken_target: assert property (
        $rose(pc_load) |-> pc_out == $past(instr_addr, 3) + 21'h2
            + {{12{$past(instr_word[7], 3)}}, $past(instr_word[7:0], 3),
               1'b0})
        else $error("taken branch target wrong");
    a_untaken_next: assert property (
        accept && is_br_w |-> ##3
            (pc_load || pc_out == $past(instr_addr, 3) + 21'h2))
        else $error("untaken branch did not fall through");
    a_taken_stall: assert property (
        $rose(pc_load) |=> !instr_ready [*4] ##1 instr_ready)
        else $error("taken branch stall length wrong");
    a_phase_order: assert property (
        (rf_rd_en |-> phase[1]) and (rf_wr_en |-> phase[3])
        and (pc_load |-> phase[3]))
        else $error("phase activity out of order");
    a_flags_kept: assert property (
        accept |-> !flag_wr_en [*8])
        else $error("status flags written");

    c_taken:   cover property ($rose(pc_load));
    c_untaken: cover property (accept && is_br_w ##3 !pc_load);
    c_clear:   cover property ($rose(rf_wr_en));
    c_apb_err: cover property (pslverr);

endmodule : bcd_core

// [core/bcd_pkg.sv]
// Constants and types for the bit-clear and flag-branch decode block
package bcd_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int PC_W    = 21;
    localparam int FADDR_W = 12;
    localparam int DATA_W  = 8;
    localparam int APB_AW  = 8;

    // ****************************************************************
    // Opcode fields
    // ****************************************************************
    localparam logic [3:0] OPC_BIT_CLEAR  = 4'h9;
    localparam logic [3:0] OPC_COND_BR    = 4'he;
    localparam logic [3:0] COND_CARRY     = 4'h2;
    localparam logic [3:0] COND_NO_CARRY  = 4'h3;
    localparam logic [3:0] COND_NO_OVFL   = 4'h5;
    localparam logic [3:0] COND_NEGATIVE  = 4'h6;
    localparam logic [3:0] COND_NON_NEG   = 4'h7;

    // ****************************************************************
    // File addressing and program counter step
    // ****************************************************************
    localparam logic [7:0] IDX_LIMIT      = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;

    // ****************************************************************
    // Register map, field positions and reset values
    // ****************************************************************
    localparam logic [APB_AW-1:0] REG_CTRL  = 8'h00;
    localparam logic [APB_AW-1:0] REG_BANK  = 8'h04;
    localparam logic [APB_AW-1:0] REG_STAT  = 8'h08;
    localparam logic [APB_AW-1:0] REG_PC    = 8'h0c;
    localparam logic [APB_AW-1:0] REG_COUNT = 8'h10;

    localparam int CTRL_EXT_BIT   = 0;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_UNSUP_BIT = 1;
    localparam int STAT_TAKEN_BIT = 2;
    localparam int STAT_FLUSH_BIT = 3;

    localparam logic            CTRL_EXT_RST = 1'b0;
    localparam logic [3:0]      BANK_RST     = 4'h0;
    localparam logic [PC_W-1:0] PC_RST       = 21'h000000;
    localparam logic [15:0]     COUNT_RST    = 16'h0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_FLUSH = 3'b100
    } bcd_state_t;

endpackage : bcd_pkg

// [core/bcd_phase_gen.sv]
// Four-phase instruction cycle generator, one-hot phase enables
`timescale 1ns/100ps
module bcd_phase_gen (
    input  wire logic       clk,
    input  wire logic       srst,
    output logic      [3:0] phase
);

    logic [3:0] phase_q;

    // Rotating one-hot; restarts at the first phase on reset
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_q <= 4'h1;
        end else begin
            phase_q <= {phase_q[2:0], phase_q[3]};
        end
    end

    assign phase = phase_q;

endmodule : bcd_phase_gen

// [tb/bcd_rf_model.sv]
// Data register file model facing the decode block
`timescale 1ns/100ps
module bcd_rf_model (
    input  wire logic        clk,
    input  wire logic        rd_en,
    input  wire logic [11:0] rd_addr,
    output logic      [7:0]  rd_data,
    input  wire logic        wr_en,
    input  wire logic [11:0] wr_addr,
    input  wire logic [7:0]  wr_data
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_q = 8'h00;

    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ {i[11:8], i[11:8]} ^ 8'h5a;
        end
    end

    // Outside the read cycle show the inverse, so stale data never passes
    assign rd_data = rd_en ? mem[rd_addr] : ~last_q;

    always @(posedge clk) begin
        if (rd_en) last_q <= mem[rd_addr];
        if (wr_en) mem[wr_addr] <= wr_data;
    end
endmodule : bcd_rf_model

// [tb/tb.sv]
// Self-checking bench for the bit-clear and flag-branch decode block
`timescale 1ns/100ps
module tb;
    logic        clk = 1'b0, srst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, instr_ready, flag_wr_en;
    logic        instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0;
    logic [20:0] instr_addr = 21'h0, pc_out;
    logic        flag_carry = 1'b0, flag_negative = 1'b0;
    logic        flag_overflow = 1'b0;
    logic [11:0] idx_base = 12'h0, rf_rd_addr, rf_wr_addr;
    logic        rf_rd_en, rf_wr_en, pc_load;
    logic [7:0]  rf_rd_data, rf_wr_data;
    logic [7:0]  shadow [0:4095];
    logic [43:0] q [$];
    logic [43:0] got;
    logic [3:0]  bank_v;
    logic [3:0]  conds [5];
    logic        ext_v = 1'b0, chain = 1'b0, last_tk = 1'b0;
    logic [20:0] pc_v = 21'h0;
    int          cyc = 0, last_acc = 0, cnt = 0;
    int          fails = 0, compares = 0;
    integer      seed;

    always #10 clk = ~clk;

    bcd_core DUT (
        .clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_addr(instr_addr), .instr_ready(instr_ready),
        .flag_carry(flag_carry), .flag_negative(flag_negative),
        .flag_overflow(flag_overflow), .flag_wr_en(flag_wr_en),
        .idx_base(idx_base), .rf_rd_en(rf_rd_en),
        .rf_rd_addr(rf_rd_addr), .rf_rd_data(rf_rd_data),
        .rf_wr_en(rf_wr_en), .rf_wr_addr(rf_wr_addr),
        .rf_wr_data(rf_wr_data), .pc_load(pc_load), .pc_out(pc_out)
    );

    bcd_rf_model rf (
        .clk(clk), .rd_en(rf_rd_en), .rd_addr(rf_rd_addr),
        .rd_data(rf_rd_data), .wr_en(rf_wr_en), .wr_addr(rf_wr_addr),
        .wr_data(rf_wr_data)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [43:0] g, input logic [43:0] x);
        compares++;
        if (g !== x) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : check

    task automatic conclude();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // Idles the instruction port first so nothing is in flight
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        instr_valid <= 1'b0;
        chain = 1'b0;
        repeat (6) @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // fl is {carry, negative, overflow}, applied once the word is taken
    task automatic issue(input logic [15:0] w, input logic [20:0] here,
                         input logic [2:0] fl);
        logic        tk;
        logic [11:0] fa;
        logic [20:0] npc;
        tk = 1'b0;
        instr_valid <= 1'b1;
        instr_word <= w;
        instr_addr <= here;
        do @(posedge clk); while (instr_ready !== 1'b1);
        {flag_carry, flag_negative, flag_overflow} <= fl;
        if (chain) begin
            check(44'(cyc - last_acc), last_tk ? 44'h8 : 44'h4);
        end
        npc = here + 21'h2;
        if (w[15:12] == bcd_pkg::OPC_BIT_CLEAR) begin
            if (w[8]) begin
                fa = {bank_v, w[7:0]};
            end else if (ext_v && w[7:0] <= bcd_pkg::IDX_LIMIT) begin
                fa = idx_base + 12'(w[7:0]);
            end else begin
                fa = {w[7:0] < bcd_pkg::ACCESS_SPLIT ?
                      bcd_pkg::ACCESS_LO_BANK : bcd_pkg::ACCESS_HI_BANK,
                      w[7:0]};
            end
            shadow[fa] = shadow[fa] & ~(8'h01 << w[11:9]);
            q.push_back({3'b010, npc, fa, shadow[fa]});
        end else if (w[15:12] != bcd_pkg::OPC_COND_BR) begin
            // Unsupported word: no strobe, counter keeps its last value
            npc = pc_v;
            q.push_back({3'b000, npc, 20'h0});
        end else begin
            case (w[11:8])
                bcd_pkg::COND_CARRY:    tk = fl[2];
                bcd_pkg::COND_NO_CARRY: tk = !fl[2];
                bcd_pkg::COND_NO_OVFL:  tk = !fl[0];
                bcd_pkg::COND_NEGATIVE: tk = fl[1];
                default:                tk = !fl[1];
            endcase
            if (tk) npc = npc + {{12{w[7]}}, w[7:0], 1'b0};
            q.push_back({2'b00, tk, npc, 20'h0});
        end
        pc_v = npc;
        last_acc = cyc;
        last_tk = tk;
        chain = 1'b1;
    endtask : issue

    // ****************************************************************
    // Monitor and run control
    // ****************************************************************
    always @(posedge clk) begin
        if (cnt == 1) begin
            got = {flag_wr_en, rf_wr_en, pc_load, pc_out,
                   rf_wr_en ? {rf_wr_addr, rf_wr_data} : 20'h0};
            check(got, q.pop_front());
        end
        if (cnt != 0) cnt--;
        if (instr_ready === 1'b1 && instr_valid === 1'b1) cnt = 3;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        seed = 32'h33dc803e;
        bank_v = 4'($random(seed));
        conds = '{bcd_pkg::COND_CARRY, bcd_pkg::COND_NO_CARRY,
                  bcd_pkg::COND_NO_OVFL, bcd_pkg::COND_NEGATIVE,
                  bcd_pkg::COND_NON_NEG};
        for (int i = 0; i < 4096; i++) begin
            shadow[i] = i[7:0] ^ {i[11:8], i[11:8]} ^ 8'h5a;
        end
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        apb(bcd_pkg::REG_CTRL, 1'b0, 32'h0);
        check({11'h0, r, e}, 44'h0);
        apb(bcd_pkg::REG_BANK, 1'b0, 32'h0);
        check({11'h0, r, e}, 44'h0);
        apb(8'h14, 1'b0, 32'h0);
        check({11'h0, r, e}, 44'h1);
        apb(bcd_pkg::REG_BANK, 1'b1, {28'h0, bank_v});
        apb(bcd_pkg::REG_BANK, 1'b0, 32'h0);
        check({11'h0, r, e}, {39'h0, bank_v, 1'b0});
        $display("test registers done");
        for (int k = 0; k < 24; k++) begin
            if (k == 16) begin
                apb(bcd_pkg::REG_CTRL, 1'b1, 32'h1);
                ext_v = 1'b1;
                idx_base <= 12'($random(seed));
            end
            issue({bcd_pkg::OPC_BIT_CLEAR, k[2:0], k[3],
                   k[4] ? 8'h5d + 8'(k[2:0]) : 8'($random(seed))},
                  {20'($random(seed)), 1'b0}, 3'h0);
        end
        $display("test bit clear done");
        for (int k = 0; k < 40; k++) begin
            issue({bcd_pkg::OPC_COND_BR, conds[k / 8],
                   k[2:0] == 3'h0 ? 8'h80 :
                   k[2:0] == 3'h1 ? 8'h7f : 8'($random(seed))},
                  {20'($random(seed)), 1'b0}, k[2:0]);
        end
        issue(16'h0000, 21'h0, 3'h0);
        instr_valid <= 1'b0;
        repeat (12) @(posedge clk);
        check(44'(q.size()), 44'h0);
        $display("test branches done");
        // Sticky unsupported flag, write-one clear, counters
        apb(bcd_pkg::REG_STAT, 1'b0, 32'h0);
        check({11'h0, r, e}, {11'h0, 32'h00000002, 1'b0});
        apb(bcd_pkg::REG_STAT, 1'b1, 32'h00000002);
        apb(bcd_pkg::REG_STAT, 1'b0, 32'h0);
        check({11'h0, r, e}, 44'h0);
        apb(bcd_pkg::REG_COUNT, 1'b0, 32'h0);
        check({11'h0, r, e}, {11'h0, 32'h00000040, 1'b0});
        apb(bcd_pkg::REG_PC, 1'b0, 32'h0);
        check({11'h0, r, e}, {22'h0, pc_v, 1'b0});
        $display("test status registers done");
        conclude();
    end
endmodule : tb
